// file: rtl/hopping_code_rx_decoder_ctrl.sv
// receive decoder control: stream sync, learn/erase, eeprom writes, switch outputs
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "rx_decoder_regs.svh"
module hopping_code_rx_decoder_ctrl
    import rx_decoder_pkg::*;
#(
    parameter int ELEM_CYC       = `ELEM_CYC,
    parameter int ERASE_HOLD_CYC = `ERASE_HOLD_CYC,
    parameter int FLASH_CYC      = `FLASH_CYC,
    parameter int EE_WAIT_CYC    = `EE_WAIT_CYC,
    parameter int NUM_OUT        = 4
) (
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire logic               rfData,
    input  wire logic               irData,
    input  wire logic               inputSourceLink,
    input  wire logic               momentaryOutputSetting,
    input  wire logic               learnButton,
    output logic                    learnIndicator,
    output logic [NUM_OUT-1:0]      dataOut,
    output logic                    lowBattery,
    output logic                    eeCs,
    output logic                    eeDi,
    output logic                    eeClkOut,
    output logic                    eeClkOen,
    input  wire logic               eeClkIn,
    input  wire logic [3:0]         addr,
    input  wire logic [31:0]        wrData,
    input  wire logic               wrStb,
    input  wire logic               rdStb,
    output logic [31:0]             rdData,
    output logic                    irq
);
    localparam int HALF = ELEM_CYC / 2;

    // receive path
    logic        rxIn;                  // selected stream
    logic        rxPrev_q;              // last stream level, for edge detect
    logic [31:0] ph_q;                  // phase within the element
    logic        elemStb;               // mid-element sample strobe
    logic [7:0]  elemSr_q;              // element history
    logic [7:0]  hist;                  // history including the new element
    logic [7:0]  idle_q;                // elements since last edge
    logic        timeout;               // end of transmission
    logic        rxActive_q;            // a transmission is in progress
    rxState_t    rxSt_q;
    logic        pairHalf_q;            // first element of a bit is held
    logic        firstElem_q;
    logic [5:0]  bitCnt_q;
    logic [`FRAME_BITS-1:0] frameSr_q;
    logic        frameStb_q;            // one cycle after last bit
    logic        markHigh_q;            // expected sync polarity
    logic        syncSeen;
    logic        runIn;
    logic        bitVal;

    assign rxIn    = inputSourceLink ? irData : rfData;
    assign elemStb = (ph_q == 32'(HALF));
    assign hist    = {elemSr_q[6:0], rxIn};
    assign runIn   = (hist[7:4] == 4'h5) || (hist[7:4] == 4'ha);
    // sync is four equal elements at the sensed polarity after run-in
    assign syncSeen = runIn && (hist[3:0] == {4{markHigh_q}});
    assign timeout  = elemStb && (idle_q == `TIMEOUT_ELEMS);
    // non-inverting path (mark low) gives data straight, inverting path flips
    assign bitVal   = firstElem_q ^ markHigh_q;

    // element clock recovery: every edge realigns the phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rxPrev_q <= 1'b0;
            ph_q     <= 32'h0;
            elemSr_q <= 8'h00;
            idle_q   <= 8'h00;
        end else begin
            rxPrev_q <= rxIn;
            if (rxIn != rxPrev_q) begin
                ph_q   <= 32'h0;
                idle_q <= 8'h00;
            end else begin
                ph_q <= (ph_q == 32'(ELEM_CYC - 1)) ? 32'h0 : ph_q + 32'h1;
                if (elemStb && idle_q != `TIMEOUT_ELEMS)
                    idle_q <= idle_q + 8'h01;
            end
            if (elemStb)
                elemSr_q <= hist;
        end
    end

    // sync hunt and manchester pair decode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rxSt_q      <= R_HUNT;
            pairHalf_q  <= 1'b0;
            firstElem_q <= 1'b0;
            bitCnt_q    <= 6'h00;
            frameSr_q   <= '0;
            frameStb_q  <= 1'b0;
            rxActive_q  <= 1'b0;
        end else begin
            frameStb_q <= 1'b0;
            if (timeout)
                rxActive_q <= 1'b0;
            else if (elemStb && syncSeen)
                rxActive_q <= 1'b1;
            case (rxSt_q)
                R_HUNT: begin
                    if (elemStb && syncSeen) begin
                        rxSt_q     <= R_DATA;
                        pairHalf_q <= 1'b0;
                        bitCnt_q   <= 6'h00;
                    end
                end
                R_DATA: begin
                    if (timeout) begin
                        rxSt_q <= R_HUNT;
                    end else if (elemStb && !pairHalf_q) begin
                        firstElem_q <= rxIn;
                        pairHalf_q  <= 1'b1;
                    end else if (elemStb) begin
                        pairHalf_q <= 1'b0;
                        // equal halves are not manchester: drop the frame
                        if (rxIn == firstElem_q) begin
                            rxSt_q <= R_HUNT;
                        end else begin
                            frameSr_q <= {bitVal, frameSr_q[`FRAME_BITS-1:1]};
                            bitCnt_q  <= bitCnt_q + 6'h01;
                            if (bitCnt_q == 6'(`FRAME_BITS - 1)) begin
                                frameStb_q <= 1'b1;
                                rxSt_q     <= R_HUNT;
                            end
                        end
                    end
                end
                default: rxSt_q <= R_HUNT;
            endcase
        end
    end

    // record table
    logic [31:0] ids_q [`MAX_RECORDS];  // local copy of learned identities
    logic [`MAX_RECORDS-1:0] valid_q;
    logic [5:0]  slot_q;                // oldest record, next to overwrite
    logic [5:0]  count_q;               // learned records, saturates at full
    logic [31:0] frameId;
    logic [3:0]  frameSw;
    logic        known;
    logic        accept;
    logic        storeRec;              // identity enters the table
    logic        clearAll;

    // table passed in so the match re-evaluates whenever an entry changes
    function automatic logic matchAny(input logic [31:0] id,
                                      input logic [`MAX_RECORDS-1:0] v,
                                      input logic [31:0] tbl [`MAX_RECORDS]);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `MAX_RECORDS; i++)
            hit = hit | (v[i] && tbl[i] == id);
        return hit;
    endfunction

    assign frameId = frameSr_q[`FR_ID_LSB +: 32];
    assign frameSw = frameSr_q[`FR_SW_LSB +: 4];
    assign known   = matchAny(frameId, valid_q, ids_q);
    assign accept  = frameStb_q && known;

    // table write: ring of fifty, wraps over the oldest entry
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            valid_q <= '0;
            slot_q  <= 6'h00;
            count_q <= 6'h00;
            for (int i = 0; i < `MAX_RECORDS; i++)
                ids_q[i] <= 32'h0;
        end else if (clearAll) begin
            valid_q <= '0;
            slot_q  <= 6'h00;
            count_q <= 6'h00;
        end else if (storeRec) begin
            ids_q[slot_q]   <= frameId;
            valid_q[slot_q] <= 1'b1;
            slot_q  <= (slot_q == 6'(`MAX_RECORDS - 1)) ? 6'h00 : slot_q + 6'h01;
            if (count_q != 6'(`MAX_RECORDS))
                count_q <= count_q + 6'h01;
        end
    end

    // switch and battery outputs
    // latched keeps last switches; momentary and low battery drop on timeout
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dataOut    <= '0;
            lowBattery <= 1'b0;
        end else if (accept) begin
            dataOut    <= frameSw[NUM_OUT-1:0];
            lowBattery <= frameSr_q[`FR_LOWBAT];
        end else if (timeout) begin
            lowBattery <= 1'b0;
            if (momentaryOutputSetting)
                dataOut <= '0;
        end
    end

    // learn and erase
    learnState_t lSt_q;
    logic [31:0] hold_q;                // button hold / flash timer
    logic [31:0] candId_q;              // identity seen by the latest frame since arming
    logic [23:0] blink_q;
    logic        eeStart;
    eeJob_t      eeJobReq;
    logic        eeDone;
    logic        learnDone;
    logic        eraseDone;

    assign storeRec  = (lSt_q == L_FIRST) && frameStb_q && (frameId == candId_q);
    assign clearAll  = (lSt_q == L_ERHOLD) && !learnButton;
    assign eeStart   = storeRec || clearAll;
    assign eeJobReq  = clearAll ? J_ERASE : J_LEARN;
    assign learnDone = (lSt_q == L_FLASH) && (hold_q == 32'(FLASH_CYC - 1));
    assign eraseDone = (lSt_q == L_ERASE) && eeDone;
    always_comb begin
        case (lSt_q)
            L_PRESS, L_ARM, L_ERHOLD: learnIndicator = 1'b1;
            L_FLASH, L_ERASE:         learnIndicator = blink_q[`BLINK_BIT];
            default:                  learnIndicator = 1'b0;
        endcase
    end

    // learn sequencer; a short press arms, a long hold erases
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lSt_q    <= L_IDLE;
            hold_q   <= 32'h0;
            candId_q <= 32'h0;
            blink_q  <= 24'h0;
        end else begin
            blink_q <= blink_q + 24'h1;
            hold_q  <= hold_q + 32'h1;
            case (lSt_q)
                L_IDLE: begin
                    hold_q <= 32'h0;
                    if (learnButton)
                        lSt_q <= L_PRESS;
                end
                L_PRESS: begin
                    if (hold_q == 32'(ERASE_HOLD_CYC - 1))
                        lSt_q <= L_ERHOLD;
                    else if (!learnButton)
                        lSt_q <= L_ARM;
                end
                L_ARM: begin
                    if (frameStb_q) begin
                        candId_q <= frameId;
                        lSt_q    <= L_FIRST;
                    end
                end
                L_FIRST: begin
                    if (storeRec)
                        lSt_q <= L_WRITE;
                    else if (frameStb_q)
                        candId_q <= frameId;
                end
                L_WRITE: begin
                    hold_q <= 32'h0;
                    if (eeDone)
                        lSt_q <= L_FLASH;
                end
                L_FLASH: if (learnDone) lSt_q <= L_IDLE;
                L_ERHOLD: if (!learnButton) lSt_q <= L_ERASE;
                L_ERASE: if (eeDone) lSt_q <= L_IDLE;
                default: lSt_q <= L_IDLE;
            endcase
        end
    end

    // serial memory engine
    eeState_t    eSt_q;
    eeJob_t      job_q;
    logic [1:0]  step_q;                // command within the job
    logic [`EE_FRAME_W-1:0] sr_q;
    logic [4:0]  eBit_q;
    logic [7:0]  eDiv_q;
    logic [31:0] eWait_q;
    logic [5:0]  wrSlot_q;              // slot being written
    logic [31:0] wrId_q;
    logic        lastStep;
    logic        busyPrev_q;

    // builds one command: start, opcode, address and data, msb first
    function automatic logic [`EE_FRAME_W-1:0] eeFrame(input eeJob_t j, input logic [1:0] s,
                                                       input logic [5:0] sl,
                                                       input logic [31:0] id);
        logic [`EE_ADDR_W-1:0] a;
        a = {2'b00, sl, s[1]};
        if (s == 2'd0)
            return {`EE_CMD_EWEN, 23'h0};
        else if (j == J_ERASE)
            return {`EE_CMD_ERAL, 23'h0};
        else
            return {`EE_CMD_WRITE, a, s[1] ? id[31:16] : id[15:0]};
    endfunction

    assign lastStep = (job_q == J_ERASE) ? (step_q == 2'd1) : (step_q == 2'd2);
    assign eeDone   = (eSt_q == E_WAIT) && (eWait_q == 32'(EE_WAIT_CYC - 1)) && lastStep;
    assign eeDi     = sr_q[`EE_FRAME_W-1];
    // pin released while deselected so the strap can be read
    assign eeClkOen = !eeCs;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            eSt_q    <= E_IDLE;
            job_q    <= J_NONE;
            step_q   <= 2'd0;
            sr_q     <= '0;
            eBit_q   <= 5'h00;
            eDiv_q   <= 8'h00;
            eWait_q  <= 32'h0;
            eeCs     <= 1'b0;
            eeClkOut <= 1'b0;
            wrSlot_q <= 6'h00;
            wrId_q   <= 32'h0;
        end else begin
            case (eSt_q)
                E_IDLE: begin
                    if (eeStart) begin
                        job_q    <= eeJobReq;
                        step_q   <= 2'd0;
                        wrSlot_q <= slot_q;
                        wrId_q   <= frameId;
                        sr_q     <= eeFrame(eeJobReq, 2'd0, slot_q, frameId);
                        eeCs     <= 1'b1;
                        eBit_q   <= 5'h00;
                        eDiv_q   <= 8'h00;
                        eSt_q    <= E_SHIFT;
                    end
                end
                E_SHIFT: begin
                    eDiv_q <= eDiv_q + 8'h01;
                    if (eDiv_q == `EE_HALF_CYC - 8'h01) begin
                        eDiv_q   <= 8'h00;
                        eeClkOut <= !eeClkOut;
                        if (eeClkOut) begin
                            sr_q   <= {sr_q[`EE_FRAME_W-2:0], 1'b0};
                            eBit_q <= eBit_q + 5'h01;
                            if (eBit_q == 5'(`EE_FRAME_W - 1)) begin
                                eeCs    <= 1'b0;
                                eWait_q <= 32'h0;
                                eSt_q   <= E_WAIT;
                            end
                        end
                    end
                end
                E_WAIT: begin
                    eWait_q <= eWait_q + 32'h1;
                    if (eWait_q == 32'(EE_WAIT_CYC - 1)) begin
                        if (lastStep) begin
                            eSt_q <= E_IDLE;
                            job_q <= J_NONE;
                        end else begin
                            step_q <= step_q + 2'd1;
                            sr_q   <= eeFrame(job_q, step_q + 2'd1, wrSlot_q, wrId_q);
                            eeCs   <= 1'b1;
                            eBit_q <= 5'h00;
                            eSt_q  <= E_SHIFT;
                        end
                    end
                end
                default: eSt_q <= E_IDLE;
            endcase
        end
    end

    // polarity strap sampled one cycle after the pin has been released
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busyPrev_q <= 1'b0;
            markHigh_q <= 1'b0;
        end else begin
            busyPrev_q <= eeCs;
            if (!eeCs && !busyPrev_q)
                markHigh_q <= eeClkIn;
        end
    end

    // register port and interrupt
    logic [`ST_WIDTH-1:0] status_q;
    logic [`ST_WIDTH-1:0] mask_q;
    logic [`ST_WIDTH-1:0] events;
    logic                 rdStatus;
    logic [31:0]          rdMux;

    assign events   = {frameStb_q && !known, accept && frameSr_q[`FR_LOWBAT],
                       eraseDone, learnDone, accept};
    assign rdStatus = rdStb && (addr == `REG_STATUS);
    assign irq      = |(status_q & mask_q);
    assign rdMux = (addr == `REG_STATUS) ? 32'(status_q) :
                   (addr == `REG_MASK)   ? 32'(mask_q) :
                   (addr == `REG_INFO)   ? {9'h0, count_q, 3'(lSt_q), markHigh_q,
                                            rxActive_q, lowBattery, 7'h0, dataOut} :
                   32'h0;

    // status clears on read, a same-cycle event still sets its bit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= '0;
            mask_q   <= '0;
            rdData   <= 32'h0;
        end else begin
            status_q <= (rdStatus ? '0 : status_q) | events;
            if (wrStb && addr == `REG_MASK)
                mask_q <= wrData[`ST_WIDTH-1:0];
            rdData <= rdStb ? rdMux : 32'h0;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_sync; (rxSt_q == R_HUNT && elemStb && syncSeen) |=> rxSt_q == R_DATA; endproperty
    a_sync: assert property (p_sync) else $error("sync not taken");
    property p_pol; (rxSt_q == R_HUNT) ##1 (rxSt_q == R_DATA) |-> $past(hist[3:0]) == {4{markHigh_q}};
    endproperty
    a_pol: assert property (p_pol) else $error("sync polarity wrong");
    property p_pin; (!eeCs && !$past(eeCs)) |=> markHigh_q == $past(eeClkIn); endproperty
    a_pin: assert property (p_pin) else $error("polarity not taken from released pin");
    property p_arm; (lSt_q == L_ARM && frameStb_q) |=> !learnIndicator; endproperty
    a_arm: assert property (p_arm) else $error("indicator not off after first frame");
    property p_wrap; (storeRec && slot_q == 6'(`MAX_RECORDS - 1)) |=> slot_q == 6'h00; endproperty
    a_wrap: assert property (p_wrap) else $error("oldest record not reused");
    property p_hold; (lSt_q == L_PRESS && hold_q == 32'(ERASE_HOLD_CYC - 1)) |=> lSt_q == L_ERHOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("long hold did not arm erase");
    property p_mirror; accept |=> dataOut == $past(frameSw[NUM_OUT-1:0]); endproperty
    a_mirror: assert property (p_mirror) else $error("outputs do not mirror switches");
    property p_batt; timeout && !accept |=> !lowBattery; endproperty
    a_batt: assert property (p_batt) else $error("low battery outlasted transmission");
    property p_latch; (timeout && !accept && !momentaryOutputSetting) |=> $stable(dataOut);
    endproperty
    a_latch: assert property (p_latch) else $error("latched output changed on timeout");
    property p_mom; (timeout && !accept && momentaryOutputSetting) |=> dataOut == '0; endproperty
    a_mom: assert property (p_mom) else $error("momentary output held after timeout");

    c_learn: cover property (learnDone);
    c_erase: cover property (eraseDone);
    c_accept: cover property (accept && momentaryOutputSetting);
endmodule

// file: rtl/rx_decoder_regs.svh
// register offsets, field positions and timing constants of the hopping-code receive decoder
// Function
// - input stream from radio or infrared by link
// - four outputs, all latched or all momentary
// - sync pattern follows alternating run-in
// - sync is four zeros or four ones
// - eeprom clock pin senses polarity when deselected
// - learn: press, first frame, repeat stores
// - fifty records, oldest overwritten when full
// - eight second hold erases all records
// - records kept in 512x16 serial memory
// - each output mirrors one encoder switch
// - low battery output only during transmission
// - timing derived from resonator reference
// - manchester elements of 400 us, short timeout
`ifndef RX_DECODER_REGS_SVH
`define RX_DECODER_REGS_SVH

`define REG_STATUS      4'h0
`define REG_MASK        4'h4
`define REG_INFO        4'h8

`define ST_FRAME        0
`define ST_LEARN        1
`define ST_ERASE        2
`define ST_LOWBAT       3
`define ST_UNKNOWN      4
`define ST_WIDTH        5

`define REF_MHZ         4
`define CLK_MHZ         40
`define ELEM_US         400
`define ELEM_CYC        (`ELEM_US * `CLK_MHZ)
`define TIMEOUT_ELEMS   8'h08
`define ERASE_HOLD_S    8
`define ERASE_HOLD_CYC  (`ERASE_HOLD_S * `CLK_MHZ * 1000000)
`define FLASH_CYC       (3 * `CLK_MHZ * 1000000)
`define EE_WAIT_CYC     (10 * `CLK_MHZ * 1000)
`define EE_HALF_CYC     8'h14
`define BLINK_BIT       22

`define MAX_RECORDS     50
`define EE_WORDS        512
`define EE_ADDR_W       9
`define EE_FRAME_W      28
`define EE_CMD_EWEN     5'h13
`define EE_CMD_ERAL     5'h12
`define EE_CMD_WRITE    3'h5

`define FR_ID_LSB       0
`define FR_SW_LSB       32
`define FR_LOWBAT       36
`define FRAME_BITS      37

`endif

// file: rtl/rx_decoder_pkg.sv
// types shared by the hopping-code receive decoder
package rx_decoder_pkg;
    typedef enum logic [0:0] {R_HUNT = 1'b0, R_DATA = 1'b1} rxState_t;
    typedef enum logic [2:0] {
        L_IDLE = 3'b000, L_PRESS = 3'b001, L_ARM = 3'b010, L_FIRST = 3'b011,
        L_WRITE = 3'b100, L_FLASH = 3'b101, L_ERHOLD = 3'b110, L_ERASE = 3'b111
    } learnState_t;
    typedef enum logic [1:0] {E_IDLE = 2'b00, E_SHIFT = 2'b01, E_WAIT = 2'b10} eeState_t;
    typedef enum logic [1:0] {J_NONE = 2'b00, J_LEARN = 2'b01, J_ERASE = 2'b10} eeJob_t;
endpackage

// file: verif/enc_tx_model.sv
// remote encoder model: manchester frames on one data line
`timescale 1ns/1ps
module enc_tx_model #(parameter int ELEM = 40) (
    input  wire logic sys_clk,
    output logic      txLine
);
    initial txLine = 1'b0;
    // one element: level held for ELEM clocks
    task automatic elem(input logic v);
        repeat (ELEM) @(posedge sys_clk) txLine <= v;
    endtask
    // run-in ends opposite the sync so its end is visible
    task automatic send(input logic pol, input logic [36:0] f);
        for (int i = 0; i < 8; i++) elem(i[0] ^ pol);
        repeat (4) elem(pol);
        for (int i = 0; i < 37; i++) begin
            elem(f[i] ^ pol);
            elem(~(f[i] ^ pol));
        end
    endtask
endmodule

// file: verif/tb_hopping_code_rx_decoder_ctrl.sv
// self-checking bench of the receive decoder control
`timescale 1ns/1ps
module tb_hopping_code_rx_decoder_ctrl;
    localparam int EL = 40; // short element keeps frames brief
    logic        sys_clk, rstn, srcLink, momSet, learnButton, strap;
    logic        wrStb, rdStb, lb, tx, learnIndicator, lowBattery;
    logic        eeCs, eeDi, eeClkOut, eeClkOen, irq;
    logic [3:0]  addr, sw, dataOut;
    logic [31:0] wrData, rdData, rdVal, stAcc;
    logic [15:0] seed, idA;
    int          err_total, comparisons;
    int          eeN = 0;  // memory commands seen
    logic [27:0] eeSr;     // bits clocked into the memory
    // strap is seen only while the pin is released
    wire         eeClkIn = eeClkOen ? strap : eeClkOut;
    hopping_code_rx_decoder_ctrl #(.ELEM_CYC(EL), .ERASE_HOLD_CYC(200),
        .FLASH_CYC(100), .EE_WAIT_CYC(50)) dut (.sys_clk, .rstn,
        .rfData(srcLink ? ~tx : tx), .irData(srcLink ? tx : ~tx),
        .inputSourceLink(srcLink), .momentaryOutputSetting(momSet), .learnButton,
        .learnIndicator, .dataOut, .lowBattery, .eeCs, .eeDi, .eeClkOut, .eeClkOen,
        .eeClkIn, .addr, .wrData, .wrStb, .rdStb, .rdData, .irq);
    enc_tx_model #(.ELEM(EL)) enc (.sys_clk, .txLine(tx));
    // repeatable stimulus source
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // memory side: one learn (enable, low, high word of slot 0), then enable and erase all
    function automatic logic [27:0] ee_exp(input int n);
        case (n)
            0, 3:    return 28'h9800000;
            1:       return {3'h5, 9'h000, idA};
            2:       return {3'h5, 9'h001, ~idA};
            default: return 28'h9000000;
        endcase
    endfunction
    always @(posedge eeClkOut) if (eeCs) begin
        eeSr <= {eeSr[26:0], eeDi};
        check(32'(eeClkOen), 32'h0);
    end
    always @(negedge eeCs) if (rstn) begin
        check(32'(eeSr), 32'(ee_exp(eeN)));
        eeN <= eeN + 1;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge sys_clk) wrStb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge sys_clk) rdStb <= 1'b0;
        @(negedge sys_clk) rdVal = rdData;
    endtask
    // poll status, which clears on read, so collect it
    task automatic wait_st(input int b);
        stAcc = '0;
        for (int n = 0; n < 2000 && stAcc[b] !== 1'b1; n++) begin
            rd(4'h0);
            stAcc = stAcc | rdVal;
        end
        check(32'(stAcc[b]), 32'h1);
        if (stAcc[b] !== 1'b1) close_out();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        {rstn, srcLink, momSet, learnButton, strap, wrStb, rdStb} = '0;
        addr = '0;
        wrData = '0;
        seed = 16'h39ab;
        err_total = 0;
        comparisons = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(4'h4);
        check(rdVal, 32'h0);
        wr(4'h4, 32'hffffffff);
        rd(4'h4);
        check(rdVal, 32'h1f);
        wr(4'hc, 32'h1);
        rd(4'hc);
        check(rdVal, 32'h0);
        seed = rnd(seed);
        idA = seed;
        // unknown encoder must not move the outputs
        enc.send(strap, {5'h03, ~idA, idA});
        check(32'(irq), 32'h1);
        check(32'(dataOut), 32'h0);
        rd(4'h0);
        check(32'(rdVal[4]), 32'h1);
        check(32'(irq), 32'h0);
        @(posedge sys_clk) learnButton <= 1'b1;
        repeat (20) @(negedge sys_clk);
        check(32'(learnIndicator), 32'h1);
        @(posedge sys_clk) learnButton <= 1'b0;
        enc.send(strap, {5'h01, ~idA, idA});
        check(32'(learnIndicator), 32'h0);
        enc.send(strap, {5'h01, ~idA, idA});
        wait_st(1);
        // each pass: source, polarity and output mode
        for (int k = 0; k < 4; k++) begin
            seed = rnd(seed);
            sw = (k == 0) ? 4'h1 : seed[3:0];
            lb = seed[4];
            @(posedge sys_clk);
            srcLink <= k[0];
            strap <= k[0];
            momSet <= k[1];
            repeat (4 * EL) @(posedge sys_clk);
            enc.send(k[0], {lb, sw, ~idA, idA});
            @(negedge sys_clk);
            check(32'(dataOut), 32'(sw));
            check(32'(lowBattery), 32'(lb));
            repeat (12 * EL) @(negedge sys_clk);
            check(32'(dataOut), k[1] ? 32'h0 : 32'(sw));
            check(32'(lowBattery), 32'h0);
        end
        wr(4'h4, 32'h0);
        @(posedge sys_clk) learnButton <= 1'b1;
        repeat (250) @(negedge sys_clk);
        check(32'(learnIndicator), 32'h1);
        @(posedge sys_clk) learnButton <= 1'b0;
        wait_st(2);
        @(negedge sys_clk);
        check(32'(learnIndicator), 32'h0);
        // erased record is unknown again, masked irq stays low
        enc.send(strap, {5'h02, ~idA, idA});
        check(32'(irq), 32'h0);
        rd(4'h0);
        check(32'(rdVal[4]), 32'h1);
        check(32'(eeN), 32'h5);
        close_out();
    end
endmodule
